//--- logic/cmbs_pkg.sv
/*
 Constants for the CAN message buffer store: window layout, buffer layout,
 identifier field positions and length code limits.
 Assumes the surrounding controller decodes the rest of the 128-byte window.
*/
`default_nettype none
package cmbs_pkg;
    localparam int WIN_BYTES = 128;
    localparam logic [6:0] OFF_CTRL_LO = 7'h00;
    localparam logic [6:0] OFF_CTRL_HI = 7'h08;
    localparam logic [6:0] OFF_RSV0_LO = 7'h09;
    localparam logic [6:0] OFF_RSV0_HI = 7'h0D;
    localparam logic [6:0] OFF_ERR_LO = 7'h0E;
    localparam logic [6:0] OFF_ERR_HI = 7'h0F;
    localparam logic [6:0] OFF_FILT_LO = 7'h10;
    localparam logic [6:0] OFF_FILT_HI = 7'h17;
    localparam logic [6:0] OFF_RSV1_LO = 7'h18;
    localparam logic [6:0] OFF_RSV1_HI = 7'h3F;
    localparam logic [2:0] SEL_RX = 3'h4;
    localparam logic [2:0] SEL_TX0 = 3'h5;
    localparam logic [2:0] SEL_TX2 = 3'h7;
    localparam int NUM_TX = 3;
    localparam int BUF_BYTES = 16;
    localparam logic [3:0] B_ID0 = 4'h0;
    localparam logic [3:0] B_ID1 = 4'h1;
    localparam logic [3:0] B_ID3 = 4'h3;
    localparam logic [3:0] B_DATA0 = 4'h4;
    localparam logic [3:0] B_DATA7 = 4'hB;
    localparam logic [3:0] B_LEN = 4'hC;
    localparam logic [3:0] B_PRIO = 4'hD;
    localparam int SRR_BIT = 4;
    localparam int IDE_BIT = 3;
    localparam int STD_RTR_BIT = 4;
    localparam int EXT_RTR_BIT = 0;
    localparam logic [3:0] MAX_COUNT = 4'h8;
    localparam logic [7:0] RD_ZERO = 8'h00;
endpackage
`default_nettype wire

//--- logic/cmbs_store.sv
/*
 Message buffer store: one receive buffer, three transmit buffers, byte
 register port for the processor and a word port for the protocol engine,
 plus local-priority selection of the transmit buffer to send.
 Assumes the protocol engine pulses sof_req just before start of frame and
 delivers a received frame as one rx_store pulse with all fields valid.
*/
// Operation
// - Decode a 128-byte window whose base is a multiple of 128.
// - Each buffer spans 16 bytes: identifiers 0-3, data 4-11, length 12, unused 14-15.
// - Priority byte at offset 13 exists only in transmit buffers.
// - Buffer contents are undefined after reset; no reset value is given. The code clears them to zero.
// - Receive buffer read-only to software; transmit buffers readable and writable anytime.
// - Identifiers are 11 or 29 bits, most significant bit sent first.
// - Smallest identifier value has highest bus priority.
// - SRR used in extended format only; software sets it, receive stores bus value.
// - Extended identifier bits, SRR, IDE and RTR map into identifier bytes 0-3.
// - Standard identifier maps into bytes 0-1 with RTR bit 4, IDE bit 3 cleared.
// - IDE one means extended, zero means standard format.
// - RTR one means remote frame, zero means data frame.
// - Remote frames send the length code as programmed but no data bytes.
// - Data frame length code gives 0 to 8 bytes in bits 3-0.
// - Up to eight data bytes; only length-code many are sent or stored.
// - Eight-bit local priority ranks transmit buffers; smallest value wins.
// - Only buffers with cleared empty flag take part right before start of frame.
// - The participating buffer with lowest local priority value is chosen.
// - On equal lowest priority the lowest buffer index is chosen.
`default_nettype none
module cmbs_store (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic win_hit,
    output logic buf_hit,
    input wire logic [8:0] win_base,
    input wire logic [2:0] tx_buffer_empty_flag,
    input wire logic sof_req,
    output logic sel_valid,
    output logic [1:0] sel_index,
    output logic sel_ide,
    output logic sel_rtr,
    output logic sel_srr,
    output logic [28:0] sel_ident,
    output logic [3:0] sel_length_code,
    output logic [3:0] sel_send_count,
    output logic [63:0] sel_payload,
    output logic sel_id_less,
    input wire logic rx_store,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic rx_srr,
    input wire logic [28:0] rx_ident,
    input wire logic [3:0] rx_length_code,
    input wire logic [63:0] rx_payload
);
    typedef logic [7:0] cmbs_byte_t;
    typedef struct packed {
        cmbs_byte_t [15:0] rx_buf;
        cmbs_byte_t [2:0][15:0] tx_buf;
        logic [7:0] rdata;
        logic hit;
        logic bhit;
        logic valid;
        logic [1:0] index;
        logic ide;
        logic rtr;
        logic srr;
        logic [28:0] ident;
        logic [3:0] dlc;
        logic [3:0] count;
        logic [63:0] payload;
        logic id_less;
    } cmbs_state_t;

    cmbs_state_t st;
    cmbs_state_t next_st;

    // Byte count from a length code, capped at eight
    function automatic logic [3:0] cmbs_count(input logic [3:0] dlc, input logic rtr);
        logic [3:0] c;
        c = (dlc > cmbs_pkg::MAX_COUNT) ? cmbs_pkg::MAX_COUNT : dlc;
        cmbs_count = rtr ? 4'h0 : c;
    endfunction

    // Extended and standard identifier packing from bytes 0-3
    function automatic logic [28:0] cmbs_ident(input cmbs_byte_t [15:0] b);
        if (b[cmbs_pkg::B_ID1][cmbs_pkg::IDE_BIT])
            cmbs_ident = {b[0], b[1][7:5], b[1][2:0], b[2], b[3][7:1]};
        else
            cmbs_ident = {18'h00000, b[0], b[1][7:5]};
    endfunction

    function automatic logic cmbs_rtr(input cmbs_byte_t [15:0] b);
        if (b[cmbs_pkg::B_ID1][cmbs_pkg::IDE_BIT])
            cmbs_rtr = b[cmbs_pkg::B_ID3][cmbs_pkg::EXT_RTR_BIT];
        else
            cmbs_rtr = b[cmbs_pkg::B_ID1][cmbs_pkg::STD_RTR_BIT];
    endfunction

    logic in_win;
    logic [6:0] off;
    logic [2:0] sel;
    logic [3:0] bidx;
    logic [1:0] win_idx;
    logic win_any;
    logic [3:0] win_cnt;
    logic [3:0] rx_cnt;
    logic [1:0] prev_idx;
    logic prev_ok;

    assign in_win = (bus_addr[15:7] == win_base);
    assign off = bus_addr[6:0];
    assign sel = off[6:4];
    assign bidx = off[3:0];

    always_comb
    begin
        next_st = st;
        win_any = 1'b0;
        win_idx = 2'h0;
        win_cnt = 4'h0;
        prev_ok = 1'b0;
        prev_idx = 2'h0;
        rx_cnt = cmbs_count(rx_length_code, rx_rtr);
        next_st.hit = in_win && (bus_rd || bus_wr);
        next_st.bhit = in_win && (bus_rd || bus_wr) && (sel >= cmbs_pkg::SEL_RX);
        next_st.rdata = cmbs_pkg::RD_ZERO;
        // Byte-wide reads; control and filter space answered by other blocks
        if (in_win && bus_rd)
        begin
            if (sel == cmbs_pkg::SEL_RX)
                next_st.rdata = (bidx == cmbs_pkg::B_PRIO) ? cmbs_pkg::RD_ZERO : st.rx_buf[bidx];
            else if (sel >= cmbs_pkg::SEL_TX0)
                next_st.rdata = st.tx_buf[2'(sel - cmbs_pkg::SEL_TX0)][bidx];
        end
        // Receive buffer ignores writes; transmit buffers take them anytime
        if (in_win && bus_wr && sel >= cmbs_pkg::SEL_TX0 && sel <= cmbs_pkg::SEL_TX2)
            next_st.tx_buf[2'(sel - cmbs_pkg::SEL_TX0)][bidx] = bus_wdata;
        // Received frame: only length-code many data bytes are replaced, none for a remote frame
        if (rx_store)
        begin
            next_st.rx_buf[cmbs_pkg::B_ID0] = rx_ide ? rx_ident[28:21] : rx_ident[10:3];
            if (rx_ide)
            begin
                next_st.rx_buf[cmbs_pkg::B_ID1] = {rx_ident[20:18], rx_srr, 1'b1, rx_ident[17:15]};
                next_st.rx_buf[2] = rx_ident[14:7];
                next_st.rx_buf[cmbs_pkg::B_ID3] = {rx_ident[6:0], rx_rtr};
            end
            else
                next_st.rx_buf[cmbs_pkg::B_ID1] = {rx_ident[2:0], rx_rtr, 1'b0, 3'h0};
            next_st.rx_buf[cmbs_pkg::B_LEN] = {4'h0, rx_length_code};
            for (int i = 0; i < 8; i++)
                if (4'(i) < rx_cnt)
                    next_st.rx_buf[4'(i) + cmbs_pkg::B_DATA0] = rx_payload[8 * i +: 8];
        end
        // Selection right before start of frame; a strict less keeps the lower index on ties
        if (sof_req)
        begin
            for (int i = 0; i < cmbs_pkg::NUM_TX; i++)
                if (!tx_buffer_empty_flag[i])
                begin
                    if (!win_any || st.tx_buf[i][cmbs_pkg::B_PRIO] < st.tx_buf[win_idx][cmbs_pkg::B_PRIO])
                    begin
                        if (win_any)
                        begin
                            prev_ok = 1'b1;
                            prev_idx = win_idx;
                        end
                        win_idx = 2'(i);
                    end
                    win_any = 1'b1;
                end
            next_st.valid = win_any;
            if (win_any)
            begin
                win_cnt = cmbs_count(st.tx_buf[win_idx][cmbs_pkg::B_LEN][3:0], cmbs_rtr(st.tx_buf[win_idx]));
                next_st.index = win_idx;
                next_st.ide = st.tx_buf[win_idx][cmbs_pkg::B_ID1][cmbs_pkg::IDE_BIT];
                next_st.rtr = cmbs_rtr(st.tx_buf[win_idx]);
                next_st.srr = st.tx_buf[win_idx][cmbs_pkg::B_ID1][cmbs_pkg::SRR_BIT];
                next_st.ident = cmbs_ident(st.tx_buf[win_idx]);
                next_st.dlc = st.tx_buf[win_idx][cmbs_pkg::B_LEN][3:0];
                next_st.count = win_cnt;
                for (int i = 0; i < 8; i++)
                    next_st.payload[8 * i +: 8] = (4'(i) < win_cnt) ?
                        st.tx_buf[win_idx][4'(i) + cmbs_pkg::B_DATA0] : 8'h00;
                // Set when the chosen buffer's identifier is smaller than the displaced candidate's, so it also wins the bus
                next_st.id_less = prev_ok &&
                    (cmbs_ident(st.tx_buf[win_idx]) < cmbs_ident(st.tx_buf[prev_idx]));
            end
        end
    end

    // Buffers cleared too for a known start; software must still treat them as undefined
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st.rx_buf <= '0;
            st.tx_buf <= '0;
            st.rdata <= 8'h00;
            st.hit <= 1'b0;
            st.bhit <= 1'b0;
            st.valid <= 1'b0;
            st.index <= 2'h0;
            st.ide <= 1'b0;
            st.rtr <= 1'b0;
            st.srr <= 1'b0;
            st.ident <= 29'h00000000;
            st.dlc <= 4'h0;
            st.count <= 4'h0;
            st.payload <= 64'h0000000000000000;
            st.id_less <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign bus_rdata = st.rdata;
    assign win_hit = st.hit;
    assign buf_hit = st.bhit;
    assign sel_valid = st.valid;
    assign sel_index = st.index;
    assign sel_ide = st.ide;
    assign sel_rtr = st.rtr;
    assign sel_srr = st.srr;
    assign sel_ident = st.ident;
    assign sel_length_code = st.dlc;
    assign sel_send_count = st.count;
    assign sel_payload = st.payload;
    assign sel_id_less = st.id_less;

    rx_read_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus_wr && !rx_store && in_win && sel == cmbs_pkg::SEL_RX) |=> $stable(st.rx_buf))
        else $error("receive buffer changed on write");
    tx_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus_wr && in_win && sel == cmbs_pkg::SEL_TX0) |=> st.tx_buf[0][$past(bidx)] == $past(bus_wdata))
        else $error("transmit write lost");
    sel_empty_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && tx_buffer_empty_flag == 3'h7) |=> !sel_valid)
        else $error("selected with all buffers empty");
    sel_part_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sof_req |=> !sel_valid || (sel_index == 2'h0 && !$past(tx_buffer_empty_flag[0]))
            || (sel_index == 2'h1 && !$past(tx_buffer_empty_flag[1]))
            || (sel_index == 2'h2 && !$past(tx_buffer_empty_flag[2])))
        else $error("empty buffer selected");
    sel_lowest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && !tx_buffer_empty_flag[0] && !tx_buffer_empty_flag[1]
            && st.tx_buf[1][cmbs_pkg::B_PRIO] < st.tx_buf[0][cmbs_pkg::B_PRIO]) |=> sel_index != 2'h0)
        else $error("higher priority value won");
    tie_index_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && !tx_buffer_empty_flag[0] && !tx_buffer_empty_flag[2]
            && st.tx_buf[0][cmbs_pkg::B_PRIO] <= st.tx_buf[2][cmbs_pkg::B_PRIO]) |=> sel_index != 2'h2)
        else $error("tie not resolved to lower index");
    remote_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_valid && sel_rtr |-> sel_send_count == 4'h0)
        else $error("remote frame with data bytes");
    count_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_send_count <= cmbs_pkg::MAX_COUNT)
        else $error("byte count above eight");
    rx_ide_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_store |=> st.rx_buf[cmbs_pkg::B_ID1][cmbs_pkg::IDE_BIT] == $past(rx_ide))
        else $error("received format flag wrong");

    // Register bus answers, one cycle after the strobe
    win_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_win && (bus_rd || bus_wr)) |=> win_hit)
        else $error("window access not flagged");
    win_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(in_win && (bus_rd || bus_wr)) |=> !win_hit)
        else $error("access outside window flagged");
    buf_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_win && (bus_rd || bus_wr) && sel >= cmbs_pkg::SEL_RX) |=> buf_hit)
        else $error("buffer access not flagged");
    ctrl_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_win && (bus_rd || bus_wr) && sel < cmbs_pkg::SEL_RX)
            |=> !buf_hit && bus_rdata == cmbs_pkg::RD_ZERO)
        else $error("control space answered by buffers");
    idle_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(in_win && bus_rd) |=> bus_rdata == cmbs_pkg::RD_ZERO)
        else $error("read data without a read");
    rx_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_win && bus_rd && sel == cmbs_pkg::SEL_RX && bidx != cmbs_pkg::B_PRIO)
            |=> bus_rdata == $past(st.rx_buf[bidx]))
        else $error("receive byte read wrong");
    rx_prio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_win && bus_rd && sel == cmbs_pkg::SEL_RX && bidx == cmbs_pkg::B_PRIO)
            |=> bus_rdata == cmbs_pkg::RD_ZERO)
        else $error("receive priority byte not zero");
    tx_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_win && bus_rd && sel >= cmbs_pkg::SEL_TX0)
            |=> bus_rdata == $past(st.tx_buf[2'(sel - cmbs_pkg::SEL_TX0)][bidx]))
        else $error("transmit byte read wrong");
    tx_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !bus_wr |=> $stable(st.tx_buf))
        else $error("transmit buffer changed without write");
    rx_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rx_store |=> $stable(st.rx_buf))
        else $error("receive buffer changed without frame");

    // Received frame lands in the visible buffer one cycle later
    rx_ext_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rx_store && rx_ide) |=> st.rx_buf[cmbs_pkg::B_ID0] == $past(rx_ident[28:21])
            && st.rx_buf[cmbs_pkg::B_ID3] == {$past(rx_ident[6:0]), $past(rx_rtr)})
        else $error("extended identifier stored wrong");
    rx_srr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rx_store && rx_ide) |=> st.rx_buf[cmbs_pkg::B_ID1][cmbs_pkg::SRR_BIT] == $past(rx_srr))
        else $error("received substitute bit wrong");
    rx_std_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rx_store && !rx_ide) |=> st.rx_buf[cmbs_pkg::B_ID0] == $past(rx_ident[10:3])
            && st.rx_buf[cmbs_pkg::B_ID1] == {$past(rx_ident[2:0]), $past(rx_rtr), 4'h0})
        else $error("standard identifier stored wrong");
    rx_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_store |=> st.rx_buf[cmbs_pkg::B_LEN] == {4'h0, $past(rx_length_code)})
        else $error("received length code wrong");
    rx_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rx_store && rx_cnt != 4'h0) |=> st.rx_buf[cmbs_pkg::B_DATA0] == $past(rx_payload[7:0]))
        else $error("first received byte lost");
    rx_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rx_store && rx_cnt < cmbs_pkg::MAX_COUNT) |=> $stable(st.rx_buf[cmbs_pkg::B_DATA7]))
        else $error("byte beyond length code stored");

    // Selection outcome, held between start-of-frame requests
    sel_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !sof_req |=> $stable(sel_valid) && $stable(sel_index) && $stable(sel_ident))
        else $error("selection changed without request");
    sel_rank_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && !tx_buffer_empty_flag[1] && !tx_buffer_empty_flag[2]
            && st.tx_buf[2][cmbs_pkg::B_PRIO] < st.tx_buf[1][cmbs_pkg::B_PRIO]) |=> sel_index != 2'h1)
        else $error("larger priority value won");
    tie_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && !tx_buffer_empty_flag[0] && !tx_buffer_empty_flag[1]
            && st.tx_buf[0][cmbs_pkg::B_PRIO] <= st.tx_buf[1][cmbs_pkg::B_PRIO]) |=> sel_index != 2'h1)
        else $error("tie not resolved to buffer zero");
    sel_fields_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && tx_buffer_empty_flag == 3'h6) |=> sel_valid && sel_index == 2'h0
            && sel_ide == $past(st.tx_buf[0][cmbs_pkg::B_ID1][cmbs_pkg::IDE_BIT])
            && sel_length_code == $past(st.tx_buf[0][cmbs_pkg::B_LEN][3:0]))
        else $error("selected fields differ from buffer zero");
    sel_srr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && tx_buffer_empty_flag == 3'h6)
            |=> sel_srr == $past(st.tx_buf[0][cmbs_pkg::B_ID1][cmbs_pkg::SRR_BIT]))
        else $error("sent substitute bit differs");
    std_ident_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sel_valid && !sel_ide) |-> sel_ident[28:11] == 18'h00000)
        else $error("standard identifier above eleven bits");
    pad_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sel_send_count < cmbs_pkg::MAX_COUNT) |-> sel_payload[63:56] == 8'h00)
        else $error("byte beyond count handed over");
    id_single_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sof_req && tx_buffer_empty_flag == 3'h5) |=> !sel_id_less)
        else $error("identifier compare without rival");
    sel_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sel_valid && !sel_rtr && sel_length_code <= cmbs_pkg::MAX_COUNT)
            |-> sel_send_count == sel_length_code)
        else $error("send count differs from length code");
endmodule
`default_nettype wire

//--- verif/cmbs_engine_model.sv
/*
 Protocol engine stand-in: pulses the start-of-frame selection and
 hands received frames to the store. Assumes the bench calls its tasks.
*/
`default_nettype none
module cmbs_engine_model (
    input wire logic ref_clk,
    output logic sof_req,
    output logic rx_store,
    output logic rx_ide,
    output logic rx_rtr,
    output logic rx_srr,
    output logic [28:0] rx_ident,
    output logic [3:0] rx_length_code,
    output logic [63:0] rx_payload
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sof_req = 1'b0;
        rx_store = 1'b0;
        {rx_ide, rx_rtr, rx_srr, rx_ident, rx_length_code, rx_payload} = '0;
    end
    task automatic pulse_sof();
        @(negedge ref_clk);
        sof_req = 1'b1;
        @(negedge ref_clk);
        sof_req = 1'b0;
    endtask
    task automatic recv(input logic ide, input logic rtr, input logic srr, input logic [28:0] id,
        input logic [3:0] len, input logic [63:0] pl);
        @(negedge ref_clk);
        rx_ide = ide;
        rx_rtr = rtr;
        rx_srr = srr;
        rx_ident = id;
        rx_length_code = len;
        rx_payload = pl;
        rx_store = 1'b1;
        @(negedge ref_clk);
        rx_store = 1'b0;
        // Stale afterwards: inverted so a late capture shows up
        {rx_ide, rx_rtr, rx_srr, rx_ident, rx_length_code, rx_payload} =
            ~{rx_ide, rx_rtr, rx_srr, rx_ident, rx_length_code, rx_payload};
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/*
 Self-checking bench for the message buffer store.
 Assumes the engine model drives the frame side; window base is 0x0500.
*/
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] BASE = 16'h0500;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [8:0] win_base = 9'h00A;
    logic [2:0] tx_buffer_empty_flag = 3'h7;
    logic [7:0] bus_rdata;
    logic win_hit, buf_hit, sel_valid, sel_ide, sel_rtr, sel_srr, sof_req, rx_store, rx_ide, rx_rtr, rx_srr;
    logic sel_id_less;
    logic [1:0] sel_index;
    logic [28:0] sel_ident, rx_ident;
    logic [3:0] sel_length_code, sel_send_count, rx_length_code;
    logic [63:0] sel_payload, rx_payload;
    int fail_count = 0;
    int compares = 0;
    always #25 ref_clk = ~ref_clk;
    cmbs_engine_model eng (.ref_clk, .sof_req, .rx_store, .rx_ide, .rx_rtr, .rx_srr, .rx_ident,
        .rx_length_code, .rx_payload);
    cmbs_store dut (.ref_clk, .rst_n, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .win_hit,
        .buf_hit, .win_base, .tx_buffer_empty_flag, .sof_req, .sel_valid, .sel_index, .sel_ide, .sel_rtr,
        .sel_srr, .sel_ident, .sel_length_code, .sel_send_count, .sel_payload, .sel_id_less, .rx_store,
        .rx_ide, .rx_rtr, .rx_srr, .rx_ident, .rx_length_code, .rx_payload);
    task automatic stop_test();
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Results land at the posedge inside; sampled at the closing negedge
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        bus_wr = w;
        bus_rd = !w;
        bus_wdata = d;
        @(negedge ref_clk);
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        acc(BASE + a, 1'b0, 8'h00);
        chk(bus_rdata, exp);
    endtask
    function automatic logic [31:0] extw(input logic [28:0] i, input logic srr, input logic rtr);
        return {i[28:18], srr, 1'b1, i[17:0], rtr};
    endfunction
    function automatic logic [63:0] keep(input logic [63:0] p, input int n);
        for (int k = n; k < 8; k++)
            p[8 * k +: 8] = 8'h00;
        return p;
    endfunction
    task automatic wtx(input int b, input logic [31:0] w, input logic [7:0] len, input logic [63:0] p,
        input logic [7:0] pr);
        logic [15:0] o;
        o = BASE + 16'h0050 + 16'(b * 16);
        for (int i = 0; i < 4; i++)
            acc(o + 16'(i), 1'b1, w[31 - 8 * i -: 8]);
        for (int i = 0; i < 8; i++)
            acc(o + 16'(4 + i), 1'b1, p[8 * i +: 8]);
        acc(o + 16'h000C, 1'b1, len);
        acc(o + 16'h000D, 1'b1, pr);
    endtask
    task automatic t_regs();
        wtx(1, 32'hA1B2C3D4, 8'h05, 64'h0123456789ABCDEF, 8'h7E);
        rd(16'h0061, 8'hB2);
        rd(16'h0066, 8'hAB);
        chk({win_hit, buf_hit}, 2'h3);
        rd(16'h006D, 8'h7E);
        rd(16'h0003, 8'h00);
        chk({win_hit, buf_hit}, 2'h2);
        acc(16'h0660, 1'b0, 8'h00);
        chk(win_hit, 1'b0);
    endtask
    task automatic t_recv();
        logic [28:0] id;
        logic [31:0] w;
        id = 29'h12345678;
        w = extw(id, 1'b1, 1'b0);
        eng.recv(1'b1, 1'b0, 1'b1, id, 4'h8, 64'h8877665544332211);
        for (int i = 0; i < 4; i++)
            rd(16'h0040 + 16'(i), w[31 - 8 * i -: 8]);
        for (int i = 0; i < 8; i++)
            rd(16'h0044 + 16'(i), 8'h11 * 8'(i + 1));
        acc(BASE + 16'h0040, 1'b1, ~w[31:24]);
        rd(16'h0040, w[31:24]);
        rd(16'h004D, 8'h00);
        eng.recv(1'b0, 1'b1, 1'b0, 29'h000005A3, 4'h3, 64'hFFEEDDCCBBAA9988);
        rd(16'h0040, 8'hB4);
        rd(16'h0041, 8'h70);
        rd(16'h0046, 8'h33);
        rd(16'h0047, 8'h44);
        rd(16'h004C, 8'h03);
        eng.recv(1'b0, 1'b0, 1'b0, 29'h000005A3, 4'h3, 64'hFFEEDDCCBBAA9988);
        rd(16'h0041, 8'h60);
        rd(16'h0046, 8'hAA);
        rd(16'h0047, 8'h44);
    endtask
    task automatic sel(input logic [2:0] f, input logic [1:0] x, input logic [28:0] id, input logic [3:0] len,
        input logic [3:0] n, input logic [63:0] p);
        tx_buffer_empty_flag = f;
        eng.pulse_sof();
        chk({sel_valid, sel_index}, {1'b1, x});
        chk({sel_ident, sel_length_code}, {id, len});
        chk({sel_send_count, sel_payload}, {n, p});
    endtask
    task automatic t_sel();
        wtx(0, extw(29'h0ABCDEF1, 1'b1, 1'b0), 8'h08, 64'h8877665544332211, 8'h05);
        wtx(1, {11'h3C5, 1'b0, 20'h00000}, 8'h0A, 64'hFFEEDDCCBBAA9988, 8'h05);
        wtx(2, extw(29'h00000123, 1'b1, 1'b1), 8'h04, 64'h8877665544332211, 8'h03);
        sel(3'h0, 2'h2, 29'h00000123, 4'h4, 4'h0, 64'h0);
        chk(sel_rtr, 1'b1);
        chk(sel_id_less, 1'b1);
        sel(3'h4, 2'h0, 29'h0ABCDEF1, 4'h8, 4'h8, 64'h8877665544332211);
        chk({sel_ide, sel_srr, sel_rtr}, 3'h6);
        chk(sel_id_less, 1'b0);
        sel(3'h5, 2'h1, 29'h000003C5, 4'hA, 4'h8, 64'hFFEEDDCCBBAA9988);
        chk(sel_ide, 1'b0);
        tx_buffer_empty_flag = 3'h7;
        eng.pulse_sof();
        chk(sel_valid, 1'b0);
        acc(BASE + 16'h005C, 1'b1, 8'h03);
        sel(3'h6, 2'h0, 29'h0ABCDEF1, 4'h3, 4'h3, keep(64'h8877665544332211, 3));
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        t_regs();
        t_recv();
        t_sel();
        stop_test();
    end
    // Whole run is under two hundred cycles; this leaves wide margin
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
